// >>> bench/sync_consumer.sv
// application-side model that timestamps and measures sync pulses
`timescale 1ns/1ps
`default_nettype none
module sync_consumer
    import sync_pkg::*;
(
    // clock and reset
    input  wire logic    ref_clk,
    input  wire logic    sys_rst,
    // time and pulses
    input  wire sys_ns_t sys_time,
    input  wire logic    sync_pulse_a,
    input  wire logic    sync_pulse_b,
    // observations
    output var sys_ns_t  rise_a,
    output var sys_ns_t  rise_b,
    output var int       count_a,
    output var int       count_b,
    output var int       width_a
);
    logic prev_a;
    logic prev_b;
    int   run_a;
    // a rise seen at this edge was launched one edge earlier
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            prev_a  <= 1'b0;
            prev_b  <= 1'b0;
            run_a   <= 0;
            count_a <= 0;
            count_b <= 0;
            width_a <= 0;
        end
        else
        begin
            prev_a <= sync_pulse_a;
            prev_b <= sync_pulse_b;
            run_a  <= sync_pulse_a ? run_a + 1 : 0;
            if (sync_pulse_a && !prev_a)
            begin
                rise_a  <= sys_time - 64'h19;
                count_a <= count_a + 1;
            end
            if (sync_pulse_b && !prev_b)
            begin
                rise_b  <= sys_time - 64'h19;
                count_b <= count_b + 1;
            end
            if (!sync_pulse_a && prev_a)
                width_a <= run_a;
        end
    end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the cyclic sync pulse unit
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import sync_pkg::*;
;
    localparam pulse_len_t LEN   = 16'h000a;
    localparam int         WIDTH = (LEN * 10 + 24) / 25;
    logic        ref_clk;
    logic        sys_rst;
    sys_ns_t     sys_time;
    logic        frame_end;
    logic        owner;
    logic [11:0] net_addr;
    logic        net_wr;
    logic        net_rd;
    logic [7:0]  net_wdata;
    logic [7:0]  net_rdata;
    logic [11:0] host_addr;
    logic        host_wr;
    logic        host_rd;
    logic [7:0]  host_wdata;
    logic [7:0]  host_rdata;
    logic        pa;
    logic        pb;
    logic [7:0]  ack_rdata;
    logic        ack_a;
    sys_ns_t     rise_a;
    sys_ns_t     rise_b;
    int          count_a;
    int          count_b;
    int          width_a;
    int          mismatches;
    int          samples_checked;
    logic [7:0]  notes[$];
    integer      seed;
    logic [31:0] rnd;
    sys_ns_t     start;
    int          c0;
    int          c1;
    logic        took_net;
    logic        took_host;

    sync_out_unit #(.PULSE_LEN(LEN)) dut_u (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .sys_time(sys_time), .frame_end(frame_end),
        .sync_owner_host(owner), .net_addr(net_addr), .net_wr(net_wr), .net_rd(net_rd),
        .net_wdata(net_wdata), .net_rdata(net_rdata), .host_addr(host_addr), .host_wr(host_wr),
        .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .sync_pulse_a(pa), .sync_pulse_b(pb));
    // second unit in acknowledge mode, same stimulus
    sync_out_unit #(.PULSE_LEN(16'h0000)) dut_ack (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .sys_time(sys_time), .frame_end(frame_end),
        .sync_owner_host(owner), .net_addr(net_addr), .net_wr(net_wr), .net_rd(net_rd),
        .net_wdata(net_wdata), .net_rdata(ack_rdata), .host_addr(host_addr), .host_wr(host_wr),
        .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(),
        .sync_pulse_a(ack_a), .sync_pulse_b());
    sync_consumer app_u (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .sys_time(sys_time), .sync_pulse_a(pa),
        .sync_pulse_b(pb), .rise_a(rise_a), .rise_b(rise_b), .count_a(count_a),
        .count_b(count_b), .width_a(width_a));

    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) sys_time <= sys_time + 64'h19;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one-cycle strobe; a read notes the byte it should return
    task automatic acc(input bit hp, input bit wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        if (hp)
        begin
            host_addr  <= a;
            host_wdata <= d;
            host_wr    <= wr;
            host_rd    <= !wr;
        end
        else
        begin
            net_addr  <= a;
            net_wdata <= d;
            net_wr    <= wr;
            net_rd    <= !wr;
        end
        if (!wr)
            notes.push_back(d);
        @(posedge ref_clk);
        {host_wr, host_rd, net_wr, net_rd} <= 4'h0;
    endtask

    task automatic wr_bytes(input logic [11:0] a, input logic [63:0] v, input int n);
        for (int i = 0; i < n; i++)
            acc(1'b0, 1'b1, a + 12'(i), v[8*i +: 8]);
    endtask

    task automatic frame;
        @(posedge ref_clk);
        frame_end <= 1'b1;
        @(posedge ref_clk);
        frame_end <= 1'b0;
    endtask

    task automatic wait_a(input int n);
        int k;
        k = 0;
        while (count_a <= n && k < 3000)
        begin
            @(posedge ref_clk);
            k++;
        end
        check(count_a > n, 1'b1);
    endtask

    // read data appears the edge after the strobe
    always @(posedge ref_clk)
    begin
        took_net  = net_rd;
        took_host = host_rd;
        #1;
        if (took_net || took_host)
            check(took_host ? host_rdata : net_rdata, notes.pop_front());
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        wrap_up();
    end

    initial
    begin
        {ref_clk, frame_end, owner, net_wr, net_rd, host_wr, host_rd} = 7'h00;
        {net_addr, host_addr, net_wdata, host_wdata} = 40'h0;
        sys_rst  = 1'b1;
        sys_time = 64'h0000_0005_0000_0000;
        seed     = 32'h8038cdda;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        acc(0, 0, 12'h981, 8'h00);
        acc(1, 0, 12'h984, 8'h00);
        acc(0, 0, 12'h982, LEN[7:0]);
        acc(0, 0, 12'h983, LEN[15:8]);
        acc(0, 1, 12'h98e, 8'hff);
        acc(0, 0, 12'h98e, 8'h00);
        acc(0, 0, 12'h985, 8'h00);
        // only the owning port may write
        rnd = $random(seed);
        acc(1, 1, 12'h9a4, rnd[7:0]);
        acc(0, 0, 12'h9a4, 8'h00);
        acc(0, 1, 12'h9a4, rnd[7:0]);
        acc(1, 0, 12'h9a4, rnd[7:0]);
        owner <= 1'b1;
        acc(0, 1, 12'h9a4, ~rnd[7:0]);
        acc(1, 1, 12'h9a5, rnd[15:8]);
        acc(0, 0, 12'h9a4, rnd[7:0]);
        acc(0, 0, 12'h9a5, rnd[15:8]);
        owner <= 1'b0;
        // debug pulses on selected outputs only
        acc(0, 1, 12'h981, 8'h82);
        acc(0, 0, 12'h981, 8'h02);
        repeat (WIDTH + 2) @(posedge ref_clk);
        check({count_a, count_b}, {32'd1, 32'd0});
        check(width_a, WIDTH);
        acc(0, 1, 12'h981, 8'h84);
        repeat (WIDTH + 2) @(posedge ref_clk);
        check({count_a, count_b}, {32'd1, 32'd1});
        // acknowledge-mode output holds until status is read
        check(ack_a, 1'b1);
        acc(0, 0, 12'h98e, 8'h00);
        repeat (2) @(posedge ref_clk);
        check({ack_rdata, ack_a}, {8'h01, 1'b0});
        // cyclic run
        wr_bytes(12'h9a0, 64'd1000, 4);
        wr_bytes(12'h9a4, 64'd300, 4);
        start = sys_time + 64'd4000;
        wr_bytes(12'h990, start, 8);
        acc(0, 1, 12'h981, 8'h07);
        acc(0, 0, 12'h984, 8'h03);
        c0 = count_a;
        c1 = count_b;
        for (int i = 0; i < 3; i++)
        begin
            wait_a(c0 + i);
            check(rise_a, start + 64'(i * 1000));
            if (i == 0)
            begin
                acc(0, 0, 12'h998, 8'(start + 64'd300));
                acc(0, 0, 12'h990, 8'(start + 64'd1000));
            end
        end
        check(rise_b, start + 64'd1300);
        check(count_b - c1, 2);
        // far-future start with short window fires at once, single shot
        acc(0, 1, 12'h981, 8'h00);
        wr_bytes(12'h9a0, 64'd0, 4);
        wr_bytes(12'h990, sys_time + 64'h1_0000_0000, 8);
        c0 = count_a;
        acc(0, 1, 12'h981, 8'h67);
        repeat (20) @(posedge ref_clk);
        acc(0, 0, 12'h984, 8'h04);
        repeat (200) @(posedge ref_clk);
        check(count_a - c0, 1);
        // lone lower half with auto activation and extension
        acc(0, 1, 12'h981, 8'h00);
        wr_bytes(12'h994, 64'd0, 4);
        frame();
        acc(0, 1, 12'h981, 8'h1a);
        start = sys_time + 64'd3000;
        wr_bytes(12'h990, start, 4);
        frame();
        acc(0, 0, 12'h981, 8'h1b);
        acc(0, 0, 12'h994, start[39:32]);
        c0 = count_a;
        wait_a(c0);
        check(rise_a, start);
        wrap_up();
    end
endmodule
`default_nettype wire

// >>> hw/sync_out_unit.sv
// cyclic sync pulse unit with two register ports
`timescale 1ns/1ps
`default_nettype none
`include "sync_params.svh"
module sync_out_unit
    import sync_pkg::*;
#(
    parameter pulse_len_t PULSE_LEN = 16'h0064
)
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // time base and write port owner
    input  wire logic [63:0] sys_time,
    input  wire logic        frame_end,
    input  wire logic        sync_owner_host,
    // network side port
    input  wire logic [11:0] net_addr,
    input  wire logic        net_wr,
    input  wire logic        net_rd,
    input  wire logic [7:0]  net_wdata,
    output logic      [7:0]  net_rdata,
    // local host port
    input  wire logic [11:0] host_addr,
    input  wire logic        host_wr,
    input  wire logic        host_rd,
    input  wire logic [7:0]  host_wdata,
    output logic      [7:0]  host_rdata,
    // sync outputs
    output logic             sync_pulse_a,
    output logic             sync_pulse_b
);
    logic [7:0]  ctrl;
    sys_ns_t     start_time;
    sys_ns_t     next_b;
    logic [31:0] cyc_a;
    logic [31:0] cyc_b;
    logic        pend_a;
    logic        pend_b;
    logic        plaus_out;
    logic        lo_wr;
    logic        hi_wr;
    logic        b_armed;
    unit_state_t state;
    unit_state_t next_state;
    logic [7:0]  next_ctrl;
    sys_ns_t     next_start;

    sync_pulse_if ia ();
    sync_pulse_if ib ();

    // the owning port is the only write source
    wire        w_en   = sync_owner_host ? host_wr : net_wr;
    wire [11:0] w_addr = sync_owner_host ? host_addr : net_addr;
    wire [7:0]  w_data = sync_owner_host ? host_wdata : net_wdata;

    wire act_wr   = w_en && (w_addr == `OFF_ACT);
    wire start_wr = w_en && ((w_addr & `MASK_QWORD) == `OFF_START);
    wire cyca_wr  = w_en && ((w_addr & `MASK_DWORD) == `OFF_CYC_A);
    wire cycb_wr  = w_en && ((w_addr & `MASK_DWORD) == `OFF_CYC_B);
    wire hi_byte  = (w_addr[2:0] >= 3'(`HIGH_HALF_BYTE));
    wire dbg      = act_wr && w_data[`B_DBG];

    // start time completion at frame end
    wire auto_on  = ctrl[`B_AUTO];
    wire do_ext   = frame_end && lo_wr && !hi_wr && (ctrl[`B_EXT] || auto_on);
    wire auto_set = frame_end && auto_on && (lo_wr || hi_wr);
    wire [31:0] ext_hi = sys_time[63:32] + 32'(start_time[31:0] < sys_time[31:0]);
    wire sys_ns_t eff_start = do_ext ? {ext_hi, start_time[31:0]} : start_time;

    // plausibility of the start time against the near future window
    wire sys_ns_t ahead   = eff_start - sys_time;
    wire          far_half  = ahead[63];
    wire          far_short = ahead[63] || (ahead[62:`NEAR_SHORT_MSB] != '0);
    wire          out_near  = next_ctrl[`B_NEAR] ? far_short : far_half;
    wire          immediate = next_ctrl[`B_PLAUS] && out_near;

    // activation register update
    always_comb
    begin
        next_ctrl = ctrl;
        if (act_wr)
            next_ctrl = {1'b0, w_data[6:0]};
        if (auto_set)
            next_ctrl[`B_RUN] = 1'b1;
    end

    wire act_rise = next_ctrl[`B_RUN] && !ctrl[`B_RUN];
    wire running  = ctrl[`B_RUN] && (state == st_armed);
    wire sys_ns_t since_a = sys_time - start_time;
    wire sys_ns_t since_b = sys_time - next_b;
    wire reach_a  = running && !act_rise && !since_a[63];
    wire reach_b  = ctrl[`B_RUN] && b_armed && !since_b[63];
    wire single   = (cyc_a == 32'h0000_0000);

    // scheduler state
    always_comb
    begin
        case (state)
            st_idle:  next_state = act_rise ? st_armed : st_idle;
            st_armed: next_state = (reach_a && single) ? st_done : st_armed;
            st_done:  next_state = act_rise ? st_armed : st_done;
            default:  next_state = st_idle;
        endcase
        if (!next_ctrl[`B_RUN])
            next_state = st_idle;
    end

    // start time register doubles as next a pulse time
    always_comb
    begin
        next_start = start_time;
        if (reach_a && !single)
            next_start = start_time + 64'(cyc_a);
        if (do_ext)
            next_start = eff_start;
        if (act_rise)
            next_start = immediate ? sys_time : eff_start;
        if (start_wr)
            next_start[{w_addr[2:0], 3'b000} +: 8] = w_data;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ctrl       <= `ACT_RESET;
            start_time <= `TIME_RESET;
            state      <= st_idle;
        end
        else
        begin
            ctrl       <= next_ctrl;
            start_time <= next_start;
            state      <= next_state;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            cyc_a <= `CYC_RESET;
            cyc_b <= `CYC_RESET;
        end
        else
        begin
            if (cyca_wr)
                cyc_a[{w_addr[1:0], 3'b000} +: 8] <= w_data;
            if (cycb_wr)
                cyc_b[{w_addr[1:0], 3'b000} +: 8] <= w_data;
        end
    end

    // frame write tracking for the upper half fill
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            lo_wr <= 1'b0;
            hi_wr <= 1'b0;
        end
        else if (start_wr)
        begin
            lo_wr <= (lo_wr && !frame_end) || !hi_byte;
            hi_wr <= (hi_wr && !frame_end) || hi_byte;
        end
        else if (frame_end)
        begin
            lo_wr <= 1'b0;
            hi_wr <= 1'b0;
        end
    end

    // next b time and first pulse bookkeeping
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            next_b    <= `TIME_RESET;
            b_armed   <= 1'b0;
            pend_a    <= 1'b0;
            pend_b    <= 1'b0;
            plaus_out <= 1'b0;
        end
        else if (!next_ctrl[`B_RUN])
        begin
            b_armed <= 1'b0;
            pend_a  <= 1'b0;
            pend_b  <= 1'b0;
        end
        else if (act_rise)
        begin
            b_armed   <= 1'b0;
            pend_a    <= next_ctrl[`B_GEN_A];
            pend_b    <= next_ctrl[`B_GEN_B];
            plaus_out <= out_near;
        end
        else
        begin
            if (reach_a)
            begin
                next_b  <= start_time + 64'(cyc_b);
                b_armed <= 1'b1;
                pend_a  <= 1'b0;
            end
            else if (reach_b)
            begin
                b_armed <= 1'b0;
                pend_b  <= 1'b0;
            end
        end
    end

    // pulse stages, generate bits gate both cyclic and debug pulses
    assign ia.fire = ctrl[`B_GEN_A] && reach_a || dbg && w_data[`B_GEN_A];
    assign ib.fire = ctrl[`B_GEN_B] && reach_b && !reach_a || dbg && w_data[`B_GEN_B];
    assign ia.len  = PULSE_LEN;
    assign ib.len  = PULSE_LEN;
    assign ia.ack  = (net_rd && net_addr == `OFF_STAT_A) || (host_rd && host_addr == `OFF_STAT_A);
    assign ib.ack  = (net_rd && net_addr == `OFF_STAT_B) || (host_rd && host_addr == `OFF_STAT_B);
    assign sync_pulse_a = ia.pulse;
    assign sync_pulse_b = ib.pulse;

    sync_pulse_stage u_stage_a (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .p       (ia.stage)
    );

    sync_pulse_stage u_stage_b (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .p       (ib.stage)
    );

    // register read decode
    function automatic logic [7:0] rd_byte(input logic [11:0] a);
        logic [5:0] sh;
        sh = {a[2:0], 3'b000};
        rd_byte = 8'h00;
        if (a == `OFF_ACT)
            rd_byte = {1'b0, ctrl[6:0]};
        else if (a == `OFF_LEN_LO)
            rd_byte = PULSE_LEN[7:0];
        else if (a == `OFF_LEN_HI)
            rd_byte = PULSE_LEN[15:8];
        else if (a == `OFF_ASTAT)
            rd_byte = {5'b00000, plaus_out, pend_b, pend_a};
        else if (a == `OFF_STAT_A)
            rd_byte = {7'b0000000, sync_pulse_a};
        else if (a == `OFF_STAT_B)
            rd_byte = {7'b0000000, sync_pulse_b};
        else if ((a & `MASK_QWORD) == `OFF_START)
            rd_byte = start_time[sh +: 8];
        else if ((a & `MASK_QWORD) == `OFF_NEXT_B)
            rd_byte = next_b[sh +: 8];
        else if ((a & `MASK_DWORD) == `OFF_CYC_A)
            rd_byte = cyc_a[{a[1:0], 3'b000} +: 8];
        else if ((a & `MASK_DWORD) == `OFF_CYC_B)
            rd_byte = cyc_b[{a[1:0], 3'b000} +: 8];
    endfunction

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            net_rdata  <= 8'h00;
            host_rdata <= 8'h00;
        end
        else
        begin
            if (net_rd)
                net_rdata <= rd_byte(net_addr);
            if (host_rd)
                host_rdata <= rd_byte(host_addr);
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence debug_write_s;
        act_wr && w_data[`B_DBG] && w_data[`B_GEN_A];
    endsequence
    sequence pulse_seen_s;
        sync_pulse_a;
    endsequence

    gate_a_a: assert property ($rose(sync_pulse_a) |-> $past(ctrl[`B_GEN_A]) || $past(dbg))
        else $error("output a rose without its generate bit");
    gate_b_a: assert property ($rose(sync_pulse_b) |-> $past(ctrl[`B_GEN_B]) || $past(dbg))
        else $error("output b rose without its generate bit");
    idle_quiet_a: assert property (!ctrl[`B_RUN] && !dbg |-> !ia.fire && !ib.fire)
        else $error("pulse fired while unit inactive");
    auto_run_a: assert property (auto_set |=> ctrl[`B_RUN])
        else $error("auto activation did not set run bit");
    debug_pulse_a: assert property (debug_write_s |=> pulse_seen_s ##0 !ctrl[`B_DBG])
        else $error("debug write gave no pulse");
    owner_lock_a: assert property (!sync_owner_host && host_wr && !net_wr |=> $stable(cyc_a) && $stable(cyc_b))
        else $error("non-owner port changed cycle time");
    pend_set_a: assert property (act_rise && next_ctrl[`B_GEN_A] |=> pend_a && state == st_armed)
        else $error("first pulse not marked pending");
    plaus_rec_a: assert property (act_rise |=> plaus_out == $past(out_near))
        else $error("plausibility result not recorded");
    single_shot_a: assert property (reach_a && single && !start_wr |=> state == st_done ##1 !reach_a)
        else $error("single shot did not stop");
    next_b_upd_a: assert property (reach_a && next_ctrl[`B_RUN] |=> next_b == $past(start_time) + 64'($past(cyc_b)))
        else $error("next b time not start plus delay");
    cycle_step_a: assert property (reach_a && !single && !start_wr && !do_ext
                                   |=> start_time == $past(start_time) + 64'($past(cyc_a)))
        else $error("next a time not advanced by cycle");
endmodule
`default_nettype wire

// >>> hw/sync_params.svh
// constants of the cyclic sync pulse unit
`ifndef SYNC_PARAMS_SVH
`define SYNC_PARAMS_SVH

// register byte addresses
`define OFF_ACT        12'h981
`define OFF_LEN_LO     12'h982
`define OFF_LEN_HI     12'h983
`define OFF_ASTAT      12'h984
`define OFF_STAT_A     12'h98e
`define OFF_STAT_B     12'h98f
`define OFF_START      12'h990
`define OFF_NEXT_B     12'h998
`define OFF_CYC_A      12'h9a0
`define OFF_CYC_B      12'h9a4
`define MASK_QWORD     12'hff8
`define MASK_DWORD     12'hffc
`define HIGH_HALF_BYTE 4

// activation register bits
`define B_RUN          0
`define B_GEN_A        1
`define B_GEN_B        2
`define B_AUTO         3
`define B_EXT          4
`define B_PLAUS        5
`define B_NEAR         6
`define B_DBG          7

// reset values
`define ACT_RESET      8'h00
`define TIME_RESET     64'h0000_0000_0000_0000
`define CYC_RESET      32'h0000_0000

// timing
`define CLK_PERIOD_NS  25
`define LEN_UNIT_NS    10
`define NEAR_SHORT_MSB 31

`endif

// >>> hw/sync_pkg.sv
// types shared by the sync pulse unit
package sync_pkg;
    typedef enum logic [1:0] {st_idle, st_armed, st_done} unit_state_t;
    typedef logic [63:0] sys_ns_t;
    typedef logic [15:0] pulse_len_t;
endpackage

// >>> hw/sync_pulse_if.sv
// link between the sync scheduler and one pulse stage
`timescale 1ns/1ps
`default_nettype none
interface sync_pulse_if;
    import sync_pkg::*;
    logic       fire;
    logic       ack;
    pulse_len_t len;
    logic       pulse;
    modport ctrl  (output fire, output ack, output len, input pulse);
    modport stage (input fire, input ack, input len, output pulse);
endinterface
`default_nettype wire

// >>> hw/sync_pulse_stage.sv
// pulse shaper for one sync output
`timescale 1ns/1ps
`default_nettype none
`include "sync_params.svh"
module sync_pulse_stage
    import sync_pkg::*;
(
    // clock and reset
    input  wire logic    ref_clk,
    input  wire logic    sys_rst,
    // scheduler side
    sync_pulse_if.stage  p
);
    logic [20:0] remain;
    wire         ack_mode = (p.len == 16'h0000);
    wire  [20:0] load_ns  = 21'(p.len) * 21'(`LEN_UNIT_NS);
    wire         more     = (remain > 21'(`CLK_PERIOD_NS));

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            p.pulse <= 1'b0;
            remain  <= 21'h000000;
        end
        else if (p.fire)
        begin
            p.pulse <= 1'b1;
            remain  <= load_ns;
        end
        else if (ack_mode)
        begin
            if (p.ack)
                p.pulse <= 1'b0;
        end
        else
        begin
            if (!more)
                p.pulse <= 1'b0;
            remain <= more ? remain - 21'(`CLK_PERIOD_NS) : 21'h000000;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    fire_sets_a: assert property (p.fire |=> p.pulse)
        else $error("fire did not raise the pulse");
    ack_hold_a: assert property (p.pulse && ack_mode && !p.ack && !p.fire |=> p.pulse)
        else $error("acknowledge mode pulse dropped without read");
    ack_clear_a: assert property (p.pulse && ack_mode && p.ack && !p.fire |=> !p.pulse)
        else $error("status read did not clear acknowledge pulse");
endmodule
`default_nettype wire
